// ### watchdog_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog block
// Assumes: One aligned 32-bit word per register on APB
// Notes:   Times are in the watchdog oscillator's own time base
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define COUNTER_PRESCALE_OPTION_ADDR 12'h000
`define WATCHDOG_STATUS_ADDR         12'h004

// ----------------------------------------------------------------
// Option fields
// ----------------------------------------------------------------
`define OPT_SOURCE_BIT  5
`define OPT_EDGE_BIT    4
`define OPT_ASSIGN_BIT  3
`define OPT_RATIO_MSB   2
`define OPT_RATIO_LSB   0
`define OPT_RESET       6'h3F

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define STAT_EXPIRED_BIT   4
`define STAT_SLEEP_BIT     3
`define STAT_HOLD_BIT      1
`define STAT_SLEEPING_BIT  0

// ----------------------------------------------------------------
// Timing, oscillator based
// ----------------------------------------------------------------
`define WDT_PERIOD_US   18000
`define HOLD_PERIOD_US  18000
`define OSC_KHZ         32

`endif

// ### watchdog_pkg.sv
// Purpose: Types shared by the watchdog block
// Assumes: Nothing beyond the map header
// Notes:   Code 2'b11 of the state is illegal
package watchdog_pkg;

  typedef enum logic [1:0] {
    RUN   = 2'b00,
    SLEEP = 2'b01,
    HOLD  = 2'b10
  } power_state_type;

endpackage : watchdog_pkg

// ### watchdog_tick_counter.sv
// Purpose: Watchdog prescaler and period counter on oscillator ticks
// Assumes: osc_tick is a one-cycle pulse per watchdog oscillator period
// Notes:   expire is a one-cycle registered pulse
`timescale 1ns/10ps
`include "watchdog_map.svh"
module watchdog_tick_counter #(
  parameter int EXPIRY_TICKS = `WDT_PERIOD_US * `OSC_KHZ / 1000,
  parameter int CNT_W        = $clog2(EXPIRY_TICKS + 1)
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       osc_tick,
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic       prescaler_assign,
  input  wire logic [2:0] prescale_ratio_sel,
  output logic            expire
);
  import watchdog_pkg::*;

  if (EXPIRY_TICKS < 2) begin : g_bad_expiry
    $error("EXPIRY_TICKS must be at least 2");
  end

  typedef struct packed {
    logic [6:0]       pre;
    logic [CNT_W-1:0] cnt;
    logic             expire;
  } tick_state_type;

  tick_state_type cur;
  tick_state_type next_cur;
  logic [7:0]     span;
  logic [6:0]     mask;
  logic           base_tick;

  // ----------------------------------------------------------------
  // Prescaler tap select
  // ----------------------------------------------------------------
  assign span      = 8'h01 << prescale_ratio_sel;
  assign mask      = span[6:0] - 7'h01;
  assign base_tick = osc_tick & (!prescaler_assign | ((cur.pre & mask) == mask));

  always_comb begin
    next_cur        = cur;
    next_cur.expire = 1'b0;
    if (clear || !enable) begin
      next_cur.pre = 7'h00;
      next_cur.cnt = '0;
    end else if (osc_tick) begin
      if (!prescaler_assign || base_tick) begin
        next_cur.pre = 7'h00;
      end else begin
        next_cur.pre = cur.pre + 7'h01;
      end
      if (base_tick) begin
        if (cur.cnt == CNT_W'(EXPIRY_TICKS - 1)) begin
          next_cur.cnt    = '0;
          next_cur.expire = 1'b1;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign expire = cur.expire;

endmodule : watchdog_tick_counter

// ### watchdog_sleep_reset_status.sv
// Purpose: Watchdog, sleep entry and wake-up, reset-cause flags, APB registers
// Assumes: Oscillator and reset pin are asynchronous and pass two flip-flops
// Notes:   The watchdog time base is the sampled oscillator pin, not pclk
//
// What this block does
// - Watchdog counts on its own oscillator, also while main clock stopped.
// - Watchdog expiry resets the device in run and in sleep.
// - Watchdog reset clears the expired flag, status bit 4.
// - Fuse enable low keeps the watchdog off forever.
// - Without prescaler the watchdog expires after about 18 ms.
// - Option register can assign the prescaler, up to 1:128.
// - Kick instruction clears counter and assigned prescaler.
// - Sleep instruction clears counter and assigned prescaler.
// - Option layout bits 5..0, bits 7:6 read zero, every reset loads 3F.
// - External reset pulse during run leaves both flags unchanged.
// - Only power-up, expiry, sleep and kick change the flags.
// - Expiry and sleep act regardless of the current flag values.
// - Sleep clears watchdog, sets expired, clears sleep flag, stops main oscillator.
// - During sleep all I/O pins hold their state.
// - Watchdog reset stays internal, reset pin never driven.
// - Sleep ends only on external reset or enabled watchdog expiry.
// - Every wake-up clears the watchdog counter.
// - Wake-up restarts through reset, not continued execution.
// - Expiry starts the start-up hold timer, core stays in reset meanwhile.
`timescale 1ns/10ps
`include "watchdog_map.svh"
module watchdog_sleep_reset_status #(
  parameter int EXPIRY_TICKS = `WDT_PERIOD_US * `OSC_KHZ / 1000,
  parameter int HOLD_TICKS   = `HOLD_PERIOD_US * `OSC_KHZ / 1000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdt_osc_in,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        watchdog_fuse_enable,
  input  wire logic        watchdog_kick_instr,
  input  wire logic        sleep_instr,
  output logic             core_reset,
  output logic             main_osc_enable,
  output logic             io_hold,
  output logic             sleeping,
  output logic             watchdog_expired_flag,
  output logic             sleep_entered_flag,
  output logic             counter_source_sel,
  output logic             counter_edge_sel,
  output logic             prescaler_assign,
  output logic [2:0]       prescale_ratio_sel
);
  import watchdog_pkg::*;

  localparam int HOLD_W = $clog2(HOLD_TICKS + 1);

  if (HOLD_TICKS < 2) begin : g_bad_hold
    $error("HOLD_TICKS must be at least 2");
  end

  typedef struct packed {
    logic [1:0]        ext_reset_pin_sync;
    logic [2:0]        osc_sync;
    logic [1:0]        fuse_sync;
    power_state_type   state;
    logic [HOLD_W-1:0] hold_cnt;
    logic              expired;
    logic              slept;
    logic [5:0]        option;
    logic [31:0]       prdata;
    logic              core_reset;
    logic              osc_en;
    logic              io_hold;
  } main_state_type;

  localparam main_state_type RESET_STATE = '{
    ext_reset_pin_sync:  2'h0,
    osc_sync:   3'h0,
    fuse_sync:  2'h0,
    state:      HOLD,
    hold_cnt:   '0,
    expired:    1'b1,
    slept:      1'b1,
    option:     `OPT_RESET,
    prdata:     32'h0000_0000,
    core_reset: 1'b1,
    osc_en:     1'b1,
    io_hold:    1'b0
  };

  main_state_type cur;
  main_state_type next_cur;

  logic ext_low;
  logic osc_tick;
  logic fuse_en;
  logic wdt_clear;
  logic expire;
  logic apb_write;
  logic apb_access;
  logic addr_hit;
  logic run_sleep;
  logic run_kick;

  // ----------------------------------------------------------------
  // Pin samples, read only past the second flop
  // ----------------------------------------------------------------
  assign ext_low  = !cur.ext_reset_pin_sync[1];
  assign osc_tick = cur.osc_sync[1] & !cur.osc_sync[2];
  assign fuse_en  = cur.fuse_sync[1];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign addr_hit   = (paddr == `COUNTER_PRESCALE_OPTION_ADDR) || (paddr == `WATCHDOG_STATUS_ADDR);
  assign apb_access = psel & penable;
  assign apb_write  = apb_access & pwrite & !cur.core_reset;
  assign pready     = 1'b1;
  assign pslverr    = apb_access & !addr_hit;

  // ----------------------------------------------------------------
  // Command qualifiers in run
  // ----------------------------------------------------------------
  assign run_sleep = (cur.state == RUN) & !ext_low & !expire & sleep_instr;
  assign run_kick  = (cur.state == RUN) & !ext_low & !expire & !sleep_instr & watchdog_kick_instr;
  // Counter held clear through the whole hold phase, so every wake starts at zero
  assign wdt_clear = (cur.state == HOLD) | run_sleep | run_kick;

  watchdog_tick_counter #(
    .EXPIRY_TICKS (EXPIRY_TICKS)
  ) u_tick_counter (
    .pclk               (pclk),
    .presetn            (presetn),
    .osc_tick           (osc_tick),
    .clear              (wdt_clear),
    .enable             (fuse_en),
    .prescaler_assign   (cur.option[`OPT_ASSIGN_BIT]),
    .prescale_ratio_sel (cur.option[`OPT_RATIO_MSB:`OPT_RATIO_LSB]),
    .expire             (expire)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur           = cur;
    next_cur.ext_reset_pin_sync = {cur.ext_reset_pin_sync[0], ext_reset_pin_n};
    next_cur.osc_sync  = {cur.osc_sync[1:0], wdt_osc_in};
    next_cur.fuse_sync = {cur.fuse_sync[0], watchdog_fuse_enable};

    if (psel && !penable) begin
      next_cur.prdata = 32'h0000_0000;
      if (paddr == `COUNTER_PRESCALE_OPTION_ADDR) begin
        next_cur.prdata[5:0] = cur.option;
      end else if (paddr == `WATCHDOG_STATUS_ADDR) begin
        next_cur.prdata[`STAT_EXPIRED_BIT]  = cur.expired;
        next_cur.prdata[`STAT_SLEEP_BIT]    = cur.slept;
        next_cur.prdata[`STAT_HOLD_BIT]     = cur.core_reset;
        next_cur.prdata[`STAT_SLEEPING_BIT] = (cur.state == SLEEP);
      end
    end

    if (apb_write && paddr == `COUNTER_PRESCALE_OPTION_ADDR) begin
      next_cur.option = pwdata[5:0];
    end

    // Reset pin is only sampled, never driven, also on internal resets
    unique case (cur.state)
      RUN: begin
        if (ext_low) begin
          next_cur.state      = HOLD;
          next_cur.core_reset = 1'b1;
          next_cur.hold_cnt   = '0;
          next_cur.option     = `OPT_RESET;
        end else if (expire) begin
          next_cur.expired    = 1'b0;
          next_cur.state      = HOLD;
          next_cur.core_reset = 1'b1;
          next_cur.hold_cnt   = '0;
          next_cur.option     = `OPT_RESET;
        end else if (sleep_instr) begin
          next_cur.expired = 1'b1;
          next_cur.slept   = 1'b0;
          next_cur.state   = SLEEP;
          next_cur.osc_en  = 1'b0;
          next_cur.io_hold = 1'b1;
        end else if (watchdog_kick_instr) begin
          next_cur.expired = 1'b1;
          next_cur.slept   = 1'b1;
        end
      end
      SLEEP: begin
        // Nothing else leaves sleep
        if (ext_low || expire) begin
          next_cur.expired    = !expire;
          next_cur.slept      = 1'b0;
          next_cur.state      = HOLD;
          next_cur.core_reset = 1'b1;
          next_cur.hold_cnt   = '0;
          next_cur.option     = `OPT_RESET;
          next_cur.osc_en     = 1'b1;
          next_cur.io_hold    = 1'b0;
        end
      end
      HOLD: begin
        next_cur.core_reset = 1'b1;
        next_cur.option     = `OPT_RESET;
        if (ext_low) begin
          next_cur.hold_cnt = '0;
        end else if (osc_tick) begin
          if (cur.hold_cnt == HOLD_W'(HOLD_TICKS - 1)) begin
            next_cur.state      = RUN;
            next_cur.core_reset = 1'b0;
            next_cur.hold_cnt   = '0;
          end else begin
            next_cur.hold_cnt = cur.hold_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_cur.state      = HOLD;
        next_cur.core_reset = 1'b1;
        next_cur.hold_cnt   = '0;
        next_cur.osc_en     = 1'b1;
        next_cur.io_hold    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                = cur.prdata;
  assign core_reset            = cur.core_reset;
  assign main_osc_enable       = cur.osc_en;
  assign io_hold               = cur.io_hold;
  assign sleeping              = (cur.state == SLEEP);
  assign watchdog_expired_flag = cur.expired;
  assign sleep_entered_flag    = cur.slept;
  assign counter_source_sel    = cur.option[`OPT_SOURCE_BIT];
  assign counter_edge_sel      = cur.option[`OPT_EDGE_BIT];
  assign prescaler_assign      = cur.option[`OPT_ASSIGN_BIT];
  assign prescale_ratio_sel    = cur.option[`OPT_RATIO_MSB:`OPT_RATIO_LSB];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking main_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RUN_EXPIRY: assert property (
    (cur.state == RUN) && !ext_low && expire |=> !watchdog_expired_flag && core_reset
      && $stable(sleep_entered_flag))
    else $error("Expiry in run did not reset with expired flag clear");

  AST_FUSE_OFF: assert property (
    !fuse_en [*2] |-> !expire)
    else $error("Watchdog expired while fuse disabled");

  AST_SLEEP_ENTRY: assert property (
    run_sleep |=> sleeping && watchdog_expired_flag && !sleep_entered_flag && !main_osc_enable)
    else $error("Sleep entry did not set flags and stop oscillator");

  AST_KICK_FLAGS: assert property (
    run_kick |=> watchdog_expired_flag && sleep_entered_flag && !core_reset)
    else $error("Kick did not set both flags");

  AST_PIN_RESET_RUN: assert property (
    (cur.state == RUN) && ext_low |=> core_reset ##0 $stable(watchdog_expired_flag)
      ##0 $stable(sleep_entered_flag))
    else $error("External reset in run changed the flags");

  AST_SLEEP_HOLDS_IO: assert property (
    sleeping |-> io_hold && !main_osc_enable && !core_reset)
    else $error("Pins not held or oscillator on during sleep");

  AST_WAKE_RESET: assert property (
    sleeping && (ext_low || expire) |=> core_reset && !sleeping && !sleep_entered_flag
      && (watchdog_expired_flag == !$past(expire)))
    else $error("Wake-up did not pass through reset with cause flags");

  AST_OPTION_LOAD: assert property (
    $rose(core_reset) |-> counter_source_sel && counter_edge_sel && prescaler_assign
      && (prescale_ratio_sel == 3'h7))
    else $error("Option not reloaded on reset");

  AST_HOLD_CLEARS: assert property (
    (cur.state == HOLD) |-> wdt_clear && core_reset ##1 !expire)
    else $error("Watchdog not held clear during the hold phase");

  AST_SLEEP_STAYS: assert property (
    sleeping && !ext_low && !expire |=> sleeping)
    else $error("Sleep left without a wake source");

  AST_OPTION_WRITE: assert property (
    apb_write && (paddr == `COUNTER_PRESCALE_OPTION_ADDR) && (cur.state == RUN) && !ext_low && !expire
      |=> ({counter_source_sel, counter_edge_sel, prescaler_assign, prescale_ratio_sel}
      == $past(pwdata[5:0])))
    else $error("Option write in run did not land");

  // Two ticks at least two cycles apart are needed before the next expiry
  AST_KICK_CLEARS: assert property (
    run_kick |=> !expire [*3])
    else $error("Kick did not restart the watchdog");

  AST_SLEEP_CLEARS: assert property (
    run_sleep |=> !expire [*3])
    else $error("Sleep entry did not restart the watchdog");

  AST_HOLD_MIN: assert property (
    $rose(core_reset) |=> core_reset [*2])
    else $error("Hold phase ended too early");

  AST_PIN_KEEPS_HOLD: assert property (
    (cur.state == HOLD) && ext_low |=> core_reset && (cur.state == HOLD))
    else $error("Hold phase left while reset pin low");

  AST_FLAGS_QUIET: assert property (
    !run_kick && !run_sleep && !expire && !(sleeping && ext_low)
      |=> $stable(watchdog_expired_flag) && $stable(sleep_entered_flag))
    else $error("Reset-cause flags changed without an event");

  AST_IO_FREE: assert property (
    !sleeping |-> !io_hold && main_osc_enable)
    else $error("Pins held or oscillator off outside sleep");

  COV_WDT_WAKE:  cover property (sleeping && expire ##1 core_reset);
  COV_PIN_WAKE:  cover property (sleeping && ext_low ##1 core_reset);
  COV_RUN_EXP:   cover property ((cur.state == RUN) && expire);
  COV_KICK:      cover property (run_kick);
  COV_PIN_RUN:   cover property ((cur.state == RUN) && ext_low);

endmodule : watchdog_sleep_reset_status

// ### core_model.sv
// Purpose: Processor core side issuing kick and sleep instruction pulses
// Assumes: Same clock as the watchdog block
// Notes:   A core held in reset executes nothing, so pulses are gated
`timescale 1ns/10ps
module core_model (
  input  wire logic pclk,
  input  wire logic core_reset,
  output logic      watchdog_kick_instr,
  output logic      sleep_instr
);
  initial begin
    watchdog_kick_instr = 1'b0;
    sleep_instr         = 1'b0;
  end

  task automatic kick();
    @(posedge pclk);
    watchdog_kick_instr <= !core_reset;
    @(posedge pclk);
    watchdog_kick_instr <= 1'b0;
  endtask : kick

  task automatic sleep();
    @(posedge pclk);
    sleep_instr <= !core_reset;
    @(posedge pclk);
    sleep_instr <= 1'b0;
  endtask : sleep
endmodule : core_model

// ### watchdog_sleep_reset_status_tb_top.sv
// Purpose: Self-checking bench for watchdog, sleep and reset-cause flags
// Assumes: Small expiry and hold counts of 4 oscillator ticks
// Notes:   Oscillator runs near 16 pclk per tick, phase unrelated
`timescale 1ns/10ps
`include "watchdog_map.svh"
module watchdog_sleep_reset_status_tb_top;
  localparam logic [11:0] OPT = `COUNTER_PRESCALE_OPTION_ADDR;
  localparam logic [11:0] STA = `WATCHDOG_STATUS_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        wdt_osc_in, ext_reset_pin_n, watchdog_fuse_enable, kick, slp;
  logic        core_reset, main_osc_enable, io_hold, sleeping, er;
  logic        watchdog_expired_flag, sleep_entered_flag;
  logic        counter_source_sel, counter_edge_sel, prescaler_assign;
  logic [2:0]  prescale_ratio_sel;
  int          t;
  int          n_errors;
  int          samples_checked;

  watchdog_sleep_reset_status #(.EXPIRY_TICKS(4), .HOLD_TICKS(4)) u_watchdog_sleep_reset_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_osc_in(wdt_osc_in), .ext_reset_pin_n(ext_reset_pin_n),
    .watchdog_fuse_enable(watchdog_fuse_enable), .watchdog_kick_instr(kick), .sleep_instr(slp),
    .core_reset(core_reset), .main_osc_enable(main_osc_enable), .io_hold(io_hold),
    .sleeping(sleeping), .watchdog_expired_flag(watchdog_expired_flag),
    .sleep_entered_flag(sleep_entered_flag), .counter_source_sel(counter_source_sel),
    .counter_edge_sel(counter_edge_sel), .prescaler_assign(prescaler_assign),
    .prescale_ratio_sel(prescale_ratio_sel));

  core_model u_core_model (.pclk(pclk), .core_reset(core_reset), .watchdog_kick_instr(kick), .sleep_instr(slp));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    wdt_osc_in = 1'b0;
    forever #64.3 wdt_osc_in = ~wdt_osc_in;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic stop(input string nm);
    $display("[ERR] %s timeout", nm);
    n_errors++;
    finish_test();
  endtask : stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stop("pready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask : rchk

  task automatic flags(input logic [1:0] e);
    chk("flags", {30'h0, e}, {30'h0, watchdog_expired_flag, sleep_entered_flag});
  endtask : flags

  task automatic wait_run();
    int n;
    for (n = 0; n < 5000 && core_reset !== 1'b0; n++) @(posedge pclk);
    if (n >= 5000) stop("run");
  endtask : wait_run

  // Counts oscillator rises until the core is put in reset
  task automatic measure(input int e);
    int   n;
    logic p;
    t = 0;
    p = wdt_osc_in;
    for (n = 0; n < 20000 && core_reset !== 1'b1; n++) begin
      @(posedge pclk);
      if (wdt_osc_in && !p) t++;
      p = wdt_osc_in;
    end
    if (n >= 20000) stop("expiry");
    samples_checked++;
    if (t < e - 1 || t > e + 1) begin
      $display("[ERR] ticks expected %0d seen %0d", e, t);
      n_errors++;
    end
  endtask : measure

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    samples_checked = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    ext_reset_pin_n = 1'b1;
    watchdog_fuse_enable = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status_hold", STA, 32'h0000001A);
    apb(1'b1, OPT, 32'h00000030);
    rchk("option_held", OPT, 32'h0000003F);
    wait_run();
    rchk("status_run", STA, 32'h00000018);
    apb(1'b1, OPT, 32'hFFFFFFFF);
    rchk("option_top", OPT, 32'h0000003F);
    apb(1'b1, OPT, 32'h00000030);
    @(posedge pclk);
    chk("fields", 32'h30, {26'h0, counter_source_sel, counter_edge_sel, prescaler_assign, prescale_ratio_sel});
    apb(1'b0, 12'h008, 32'h00000000);
    chk("unmapped", 32'h00000001, {rd[30:0], er});
    apb(1'b1, STA, 32'h00000000);
    rchk("status_ro", STA, 32'h00000018);
    $display("test registers done");
    repeat (30) begin
      u_core_model.kick();
      repeat (26) @(posedge pclk);
    end
    chk("kept", 32'h0, {31'h0, core_reset});
    flags(2'b11);
    u_core_model.kick();
    measure(4);
    flags(2'b01);
    chk("option_rst", 32'h1, {31'h0, prescaler_assign});
    wait_run();
    u_core_model.kick();
    repeat (2) @(posedge pclk);
    flags(2'b11);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, OPT, 32'h00000008 | r);
      u_core_model.kick();
      measure(4 << r);
      wait_run();
    end
    apb(1'b1, OPT, 32'h00000030);
    measure(4);
    flags(2'b01);
    wait_run();
    $display("test expiry done");
    apb(1'b1, OPT, 32'h00000030);
    u_core_model.sleep();
    repeat (2) @(posedge pclk);
    chk("sleep", 32'h16, {27'h0, sleeping, main_osc_enable, io_hold, watchdog_expired_flag, sleep_entered_flag});
    measure(4);
    repeat (2) @(posedge pclk);
    chk("wdt_wake", 32'h28, {26'h0, core_reset, sleeping, main_osc_enable, io_hold, watchdog_expired_flag, sleep_entered_flag});
    wait_run();
    apb(1'b1, OPT, 32'h00000030);
    u_core_model.sleep();
    ext_reset_pin_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("pin_wake", 32'hA, {28'h0, core_reset, sleeping, watchdog_expired_flag, sleep_entered_flag});
    ext_reset_pin_n <= 1'b1;
    wait_run();
    apb(1'b1, OPT, 32'h00000030);
    ext_reset_pin_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("pin_run", 32'h6, {29'h0, core_reset, watchdog_expired_flag, sleep_entered_flag});
    ext_reset_pin_n <= 1'b1;
    wait_run();
    rchk("option_pin", OPT, 32'h0000003F);
    $display("test sleep done");
    watchdog_fuse_enable <= 1'b0;
    apb(1'b1, OPT, 32'h00000030);
    repeat (300) @(posedge pclk);
    chk("fuse_off", 32'h0, {31'h0, core_reset});
    u_core_model.sleep();
    repeat (300) @(posedge pclk);
    chk("no_wake", 32'h1, {31'h0, sleeping});
    $display("test fuse done");
    finish_test();
  end
endmodule : watchdog_sleep_reset_status_tb_top
